// ===== sac_common.sv
// Shared constants and the input synchroniser for the serial conversion port.
package sac_pkg;
  localparam int unsigned SAC_RES_W = 16;
  localparam int unsigned SAC_CFG_W = 2;
  localparam int unsigned SAC_CLK_PERIOD_NS = 25;
  localparam int unsigned SAC_CONVERT_STROBE_TIME_NS = 3500;
  localparam int unsigned SAC_CONVERT_STROBE_CYCLES =
    (SAC_CONVERT_STROBE_TIME_NS + SAC_CLK_PERIOD_NS - 1) / SAC_CLK_PERIOD_NS;
  localparam logic [1:0] SAC_CFG_RESET = 2'h2;
  localparam int unsigned SAC_CFG_SGL_BIT = 1;
  localparam int unsigned SAC_CFG_ODD_BIT = 0;
  localparam logic [SAC_RES_W-1:0] SAC_ZERO_CODE = 16'h0000;
  localparam logic [SAC_RES_W-1:0] SAC_FULL_CODE = 16'hFFFF;

  typedef enum logic [1:0] {
    SAC_ST_SAMPLE = 2'h0,
    SAC_ST_CONVERT = 2'h1,
    SAC_ST_SLEEP = 2'h3
  } sac_state_t;
endpackage : sac_pkg

`timescale 1ns/1ps
module sac_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;

  if (WIDTH < 1) begin : g_bad_width
    $error("sac_sync width must be at least one");
  end

  // Two flip-flops; the first is read only by the second.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule : sac_sync

// ===== sac_port.sv
// Conversion sequencer and three-wire serial port of a 16-bit converter.
`timescale 1ns/1ps
module sac_port
  import sac_pkg::*;
#(
  parameter bit TWO_CHANNEL = 1'b1,
  parameter int unsigned CONVERT_STROBE_CYCLES = SAC_CONVERT_STROBE_CYCLES
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic convert_strobe_i,
  input wire logic shift_clock_i,
  input wire logic serial_config_in_i,
  input wire logic [SAC_RES_W-1:0] analog_channel_zero_i,
  input wire logic [SAC_RES_W-1:0] analog_channel_one_i,
  output logic serial_result_out_o,
  output logic serial_result_oe_o,
  output logic busy_o,
  output logic sleep_o
);
  localparam int unsigned CNT_W = $clog2(CONVERT_STROBE_CYCLES + 1);

  logic [2:0] pin_sync;
  logic strobe_s, sck_s, sdi_s;
  logic strobe_prev_q, sck_prev_q;
  logic strobe_rise, strobe_fall, sck_rise, sck_fall;
  sac_state_t state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [SAC_RES_W-1:0] pos_q, neg_q, result_q, shreg_q;
  logic [SAC_CFG_W-1:0] cfg_q, cfg_shift_q;
  logic [1:0] cfg_cnt_q;
  logic [SAC_RES_W-1:0] pos_sel, neg_sel;
  logic convert_strobe_done;

  // The length check below cannot span more than 301 cycles.
  if (CONVERT_STROBE_CYCLES < 1 || CONVERT_STROBE_CYCLES > 301) begin : g_bad_convert_strobe_cycles
    $error("conversion length out of range");
  end

  sac_sync #(.WIDTH(3)) u_sync (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .async_i({convert_strobe_i, shift_clock_i, serial_config_in_i}),
    .sync_o(pin_sync)
  );
  assign strobe_s = pin_sync[2];
  assign sck_s = pin_sync[1];
  assign sdi_s = pin_sync[0];

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      strobe_prev_q <= 1'b0;
      sck_prev_q <= 1'b0;
    end else begin
      strobe_prev_q <= strobe_s;
      sck_prev_q <= sck_s;
    end
  end
  assign strobe_rise = strobe_s & ~strobe_prev_q;
  assign strobe_fall = ~strobe_s & strobe_prev_q;
  assign sck_rise = sck_s & ~sck_prev_q;
  assign sck_fall = ~sck_s & sck_prev_q;
  assign convert_strobe_done = (state_q == SAC_ST_CONVERT) && (cnt_q == '0);

  // Input multiplexer setting from the captured configuration.
  always_comb begin
    pos_sel = analog_channel_zero_i;
    neg_sel = analog_channel_one_i;
    if (TWO_CHANNEL) begin
      if (cfg_q[SAC_CFG_SGL_BIT]) begin
        pos_sel = cfg_q[SAC_CFG_ODD_BIT] ? analog_channel_one_i : analog_channel_zero_i;
        neg_sel = SAC_ZERO_CODE;
      end else begin
        pos_sel = cfg_q[SAC_CFG_ODD_BIT] ? analog_channel_one_i : analog_channel_zero_i;
        neg_sel = cfg_q[SAC_CFG_ODD_BIT] ? analog_channel_zero_i : analog_channel_one_i;
      end
    end
  end

  // Sequencer: sample, convert, sleep.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= SAC_ST_SAMPLE;
      cnt_q <= '0;
    end else begin
      unique case (state_q)
        SAC_ST_SAMPLE: begin
          if (strobe_rise) begin
            state_q <= SAC_ST_CONVERT;
            cnt_q <= CNT_W'(CONVERT_STROBE_CYCLES - 1);
          end
        end
        SAC_ST_CONVERT: begin
          if (strobe_fall) begin
            state_q <= SAC_ST_SAMPLE;
          end else if (convert_strobe_done) begin
            state_q <= SAC_ST_SLEEP;
          end else begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
        SAC_ST_SLEEP: begin
          if (strobe_fall) begin
            state_q <= SAC_ST_SAMPLE;
          end
        end
        default: state_q <= SAC_ST_SAMPLE;
      endcase
    end
  end

  // Track and hold: inputs are frozen on the rising strobe, result at conversion end.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pos_q <= SAC_ZERO_CODE;
      neg_q <= SAC_ZERO_CODE;
      result_q <= SAC_ZERO_CODE;
    end else begin
      if (state_q == SAC_ST_SAMPLE && strobe_rise) begin
        pos_q <= pos_sel;
        neg_q <= neg_sel;
      end
      if (convert_strobe_done && !strobe_fall) begin
        result_q <= (pos_q > neg_q) ? (pos_q - neg_q) : SAC_ZERO_CODE;
      end
    end
  end

  // Result shifter, MSB first, zero fill after the last bit.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      shreg_q <= SAC_ZERO_CODE;
      serial_result_oe_o <= 1'b0;
    end else begin
      if (strobe_fall) begin
        shreg_q <= result_q;
        serial_result_oe_o <= 1'b1;
      end else if (strobe_s) begin
        serial_result_oe_o <= 1'b0;
      end else if (sck_fall) begin
        shreg_q <= {shreg_q[SAC_RES_W-2:0], 1'b0};
      end
    end
  end
  assign serial_result_out_o = shreg_q[SAC_RES_W-1];

  // Configuration capture: first two rising edges after the strobe falls.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_q <= SAC_CFG_RESET;
      cfg_shift_q <= '0;
      cfg_cnt_q <= 2'h0;
    end else begin
      if (strobe_fall) begin
        cfg_cnt_q <= 2'h0;
      end else if (TWO_CHANNEL && !strobe_s && sck_rise && cfg_cnt_q < 2'h2) begin
        cfg_shift_q <= {cfg_shift_q[0], sdi_s};
        cfg_cnt_q <= cfg_cnt_q + 2'h1;
        if (cfg_cnt_q == 2'h1) begin
          cfg_q <= {cfg_shift_q[0], sdi_s};
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_o <= 1'b0;
      sleep_o <= 1'b0;
    end else begin
      busy_o <= (state_q == SAC_ST_CONVERT) && !convert_strobe_done;
      sleep_o <= (state_q == SAC_ST_SLEEP) || (convert_strobe_done && strobe_s && !strobe_fall);
    end
  end

  a_convert_strobe_start: assert property (@(posedge clock_i) disable iff (!resetn_i)
    state_q == SAC_ST_SAMPLE && strobe_rise |=> state_q == SAC_ST_CONVERT)
    else $error("rising strobe did not start a conversion");

  a_convert_strobe_length: assert property (@(posedge clock_i) disable iff (!resetn_i)
    state_q == SAC_ST_CONVERT && cnt_q == CNT_W'(CONVERT_STROBE_CYCLES - 1) && strobe_s
      |-> ##(CONVERT_STROBE_CYCLES - 1) (cnt_q == '0 || !strobe_s))
    else $error("conversion counter length wrong");

  a_sleep_entry: assert property (@(posedge clock_i) disable iff (!resetn_i)
    convert_strobe_done && strobe_s |=> state_q == SAC_ST_SLEEP ##1 sleep_o)
    else $error("no sleep after conversion with strobe high");

  a_fall_enable: assert property (@(posedge clock_i) disable iff (!resetn_i)
    strobe_fall |=> serial_result_oe_o && state_q == SAC_ST_SAMPLE)
    else $error("falling strobe did not enable output");

  a_oe_strobe_low: assert property (@(posedge clock_i) disable iff (!resetn_i)
    serial_result_oe_o |-> $past(!strobe_s))
    else $error("output driven while strobe high");

  a_shift_fall: assert property (@(posedge clock_i) disable iff (!resetn_i)
    sck_fall && !strobe_s && !strobe_fall |=> serial_result_out_o == $past(shreg_q[14]))
    else $error("result bit not advanced on falling shift clock");

  a_zero_fill: assert property (@(posedge clock_i) disable iff (!resetn_i)
    shreg_q == SAC_ZERO_CODE && !strobe_fall |=> !serial_result_out_o)
    else $error("output not zero after result bits");

  a_msb_first: assert property (@(posedge clock_i) disable iff (!resetn_i)
    strobe_fall |=> serial_result_out_o == $past(result_q[SAC_RES_W-1]))
    else $error("first bit is not the most significant");

  a_cfg_limit: assert property (@(posedge clock_i) disable iff (!resetn_i)
    cfg_cnt_q == 2'h2 && !strobe_fall |=> $stable(cfg_q) && cfg_cnt_q == 2'h2)
    else $error("configuration changed after two bits");

  a_result_range: assert property (@(posedge clock_i) disable iff (!resetn_i)
    convert_strobe_done && !strobe_fall && pos_q <= neg_q |=> result_q == SAC_ZERO_CODE)
    else $error("non-positive difference did not give zero code");
endmodule : sac_port

// ===== sac_host.sv
// Host model that drives the strobe, the shift clock and the configuration input.
`timescale 1ns/1ps
module sac_host (
  input wire logic clock_i,
  input wire logic serial_result_out_i,
  output logic convert_strobe_o,
  output logic shift_clock_o,
  output logic serial_config_in_o
);
  initial begin
    convert_strobe_o = 1'b0;
    shift_clock_o = 1'b0;
    serial_config_in_o = 1'b0;
  end

  // Raises the strobe; the caller decides how long it stays high.
  task automatic convert();
    @(posedge clock_i);
    convert_strobe_o <= 1'b1;
  endtask : convert

  // Drops the strobe and runs twenty shift clocks, sending four input bits.
  task automatic read(input logic [3:0] cfg, output logic [19:0] got);
    @(posedge clock_i);
    convert_strobe_o <= 1'b0;
    repeat (5) @(posedge clock_i);
    for (int i = 19; i >= 0; i--) begin
      serial_config_in_o <= (i >= 16) ? cfg[i-16] : ~serial_config_in_o;
      repeat (5) @(posedge clock_i);
      shift_clock_o <= 1'b1;
      got[i] = serial_result_out_i;
      repeat (3) @(posedge clock_i);
      shift_clock_o <= 1'b0;
    end
  endtask : read
endmodule : sac_host

// ===== sac_port_bench.sv
// Self-checking bench for the serial conversion port.
`timescale 1ns/1ps
module sac_port_bench;
  import sac_pkg::*;
  localparam int unsigned CONVERT_STROBE_N = 8;
  localparam logic [15:0] A_TAB [5] = '{16'h1234, 16'h8000, 16'h1000, 16'h0000, 16'h0005};
  localparam logic [15:0] B_TAB [5] = '{16'h5678, 16'h8000, 16'hFFFF, 16'hFFFF, 16'h0009};
  localparam logic [3:0] SDI_TAB [5] = '{4'h3, 4'h6, 4'hC, 4'h1, 4'h8};
  logic clock_i;
  logic resetn_i;
  logic strobe;
  logic sck;
  logic serial_config_in;
  logic serial_result_out;
  logic sdo_line;
  logic oe;
  logic busy;
  logic sleep;
  logic [SAC_RES_W-1:0] ch_zero;
  logic [SAC_RES_W-1:0] ch_one;
  logic [1:0] cfg_now;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;

  sac_port #(.TWO_CHANNEL(1'b1), .CONVERT_STROBE_CYCLES(CONVERT_STROBE_N)) dut_u (
    .clock_i(clock_i), .resetn_i(resetn_i), .convert_strobe_i(strobe),
    .shift_clock_i(sck), .serial_config_in_i(serial_config_in), .analog_channel_zero_i(ch_zero),
    .analog_channel_one_i(ch_one), .serial_result_out_o(serial_result_out),
    .serial_result_oe_o(oe), .busy_o(busy), .sleep_o(sleep));
  // A released output shows the inverse of its data, so a read while released fails.
  assign sdo_line = oe ? serial_result_out : ~serial_result_out;
  sac_host host_u (.clock_i(clock_i), .serial_result_out_i(sdo_line),
    .convert_strobe_o(strobe), .shift_clock_o(sck), .serial_config_in_o(serial_config_in));

  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic cmp_flag(input string name, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %b seen %b", name, exp, got);
    end
  endtask : cmp_flag

  task automatic cmp_word(input string name, input logic [19:0] exp, input logic [19:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp_word

  function automatic logic [15:0] expect_code(logic [1:0] c, logic [15:0] a, logic [15:0] b);
    if (c[1]) return c[0] ? b : a;
    if (!c[0]) return (a > b) ? a - b : 16'h0000;
    return (b > a) ? b - a : 16'h0000;
  endfunction : expect_code

  // Output enable and busy are quiet straight after reset.
  task automatic t_reset_state();
    cmp_flag("oe_reset", 1'b0, oe);
    cmp_flag("busy_reset", 1'b0, busy);
  endtask : t_reset_state

  // Each conversion is read back while the next configuration is sent.
  task automatic t_convert_table();
    logic [19:0] got;
    cfg_now = SAC_CFG_RESET;
    for (int i = 0; i < 5; i++) begin
      @(posedge clock_i);
      ch_zero <= A_TAB[i];
      ch_one <= B_TAB[i];
      host_u.convert();
      repeat (6) @(posedge clock_i);
      cmp_flag("busy", 1'b1, busy);
      repeat (20) @(posedge clock_i);
      cmp_flag("sleep", 1'b1, sleep);
      cmp_flag("busy_end", 1'b0, busy);
      cmp_flag("oe_high_strobe", 1'b0, oe);
      host_u.read(SDI_TAB[i], got);
      cmp_flag("oe_low_strobe", 1'b1, oe);
      cmp_flag("sleep_woken", 1'b0, sleep);
      cmp_word("result", {expect_code(cfg_now, A_TAB[i], B_TAB[i]), 4'h0}, got);
      cfg_now = SDI_TAB[i][3:2];
    end
  endtask : t_convert_table

  // A strobe that falls mid-conversion aborts it and the previous result is sent.
  task automatic t_abort();
    logic [19:0] got;
    @(posedge clock_i);
    ch_zero <= 16'h4321;
    ch_one <= 16'h0000;
    host_u.convert();
    repeat (5) @(posedge clock_i);
    cmp_flag("busy_abort", 1'b1, busy);
    host_u.read(4'h8, got);
    cmp_flag("busy_aborted", 1'b0, busy);
    cmp_flag("sleep_abort", 1'b0, sleep);
    cmp_flag("oe_abort", 1'b1, oe);
    cmp_word("result_abort", {expect_code(SDI_TAB[3][3:2], A_TAB[4], B_TAB[4]), 4'h0}, got);
  endtask : t_abort

  task automatic tally_and_finish();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    resetn_i = 1'b0;
    ch_zero = 16'h0000;
    ch_one = 16'h0000;
    repeat (2) @(posedge clock_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    t_reset_state();
    t_convert_table();
    t_abort();
    tally_and_finish();
  end
endmodule : sac_port_bench
